// >>> fogx_exit_seq.sv
/*
  XIP recovery burst detector.
  Assumes synchronous pins and a serial clock slow
  enough that each level lasts a clock.
*/
`timescale 1ns/1ps
`default_nettype none

module fogx_exit_seq
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Link to the gate
  fogx_link_if.det  lnk
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [5:0] cnt_reg,  cnt_next;   // Clocks in this burst
  logic       high_reg, high_next;  // Line zero high so far
  logic [2:0] step_reg, step_next;  // Bursts matched
  logic       sck_reg,  cs_reg;     // Previous pin levels
  logic       exit_reg, exit_next;  // Exit pulse

  // Expected clocks for a step
  function automatic logic [5:0] burstLen(input logic [2:0] s);
    case (s)
      3'h0:    burstLen = fogx_pkg::BURST_0;
      3'h1:    burstLen = fogx_pkg::BURST_1;
      3'h2:    burstLen = fogx_pkg::BURST_2;
      3'h3:    burstLen = fogx_pkg::BURST_3;
      default: burstLen = fogx_pkg::BURST_4;
    endcase
  endfunction : burstLen

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    cnt_next  = cnt_reg;
    high_next = high_reg;
    step_next = step_reg;
    exit_next = 1'b0;
    // Burst opens: restart count
    if (cs_reg && !lnk.csN)
    begin
      cnt_next  = 6'h00;
      high_next = 1'b1;
    end
    // Rising serial clock in burst
    else if (!lnk.csN && lnk.sckPin && !sck_reg)
    begin
      if (cnt_reg != 6'h3F)
        cnt_next = cnt_reg + 6'h01;
      if (!lnk.dataZero)
        high_next = 1'b0;
    end
    // Burst closes: compare
    else if (!cs_reg && lnk.csN)
    begin
      if (high_reg && cnt_reg == burstLen(step_reg))
      begin
        if (step_reg == 3'(fogx_pkg::EXIT_STEPS - 1))
        begin
          step_next = 3'h0;
          exit_next = 1'b1;
        end
        else
          step_next = step_reg + 3'h1;
      end
      // Wrong burst may restart pattern
      else if (high_reg && cnt_reg == fogx_pkg::BURST_0)
        step_next = 3'h1;
      else
        step_next = 3'h0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_reg  <= 6'h00;
      high_reg <= 1'b0;
      step_reg <= 3'h0;
      sck_reg  <= 1'b0;
      cs_reg   <= 1'b1;
      exit_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      high_reg <= high_next;
      step_reg <= step_next;
      sck_reg  <= lnk.sckPin;
      cs_reg   <= lnk.csN;
      exit_reg <= exit_next;
    end
  end

  assign lnk.exitPulse = exit_reg;

endmodule : fogx_exit_seq

`default_nettype wire

// >>> fogx_gate.sv
/*
  Operation admission and XIP control for a flash.
  Assumes a decoder giving one class per
  command, an engine reporting completion and a
  flag on the first dummy cycle of a fast read.
*/
`timescale 1ns/1ps
`default_nettype none

module fogx_gate
#(
  parameter int SECT_W = 8,   // Sector index width
  parameter int BANK_W = 2    // Bank index width
)
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Decoded command
  input  wire logic              cmdValid,
  input  wire fogx_pkg::fogx_op_t cmdOp,
  input  wire logic [SECT_W-1:0] cmdSector,
  input  wire logic [BANK_W-1:0] cmdBank,
  input  wire logic              cmdSubsector,
  input  wire logic              cmdXipByte,
  input  wire logic [7:0]        cmdData,
  // Array engine
  input  wire logic              opDone,
  // Options and configuration
  input  wire logic              rwwOption,
  input  wire logic              extendedSpi,
  input  wire logic [7:0]        nvXipByte,
  // Fast read first dummy cycle
  input  wire logic              dummyFirst,
  input  wire logic [7:0]        dummyLines,
  // Pins
  input  wire logic              hwResetN,
  input  wire logic              sckPin,
  input  wire logic              csN,
  input  wire logic              dataLineZero,
  // Command answer
  output logic                   cmdAccept,
  output logic                   cmdReject,
  output logic                   dataUnsure,
  output logic                   peStart,
  // Device status
  output fogx_pkg::fogx_state_t  devState,
  output logic                   xipActive,
  output logic                   addrOnly,
  output logic [7:0]             xipCfg,
  output fogx_pkg::fogx_rtype_t  readType
);

  // ----------------------------------------------------------------
  // Recovery detector
  // ----------------------------------------------------------------
  fogx_link_if lnk ();

  assign lnk.sckPin   = sckPin;
  assign lnk.csN      = csN;
  assign lnk.dataZero = dataLineZero;

  fogx_exit_seq u_exit
  (
    .clk   (clk),
    .rst_n (rst_n),
    .lnk   (lnk)
  );

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Valid XIP byte test
  function automatic logic xipValid(input logic [7:0] b);
    xipValid = (b == fogx_pkg::XIP_FAST) ||
               (b == fogx_pkg::XIP_OCT_OUT) ||
               (b == fogx_pkg::XIP_OCT_IO);
  endfunction : xipValid

  // Read type for a config byte
  function automatic fogx_pkg::fogx_rtype_t rtOf(input logic [7:0] b);
    if (b == fogx_pkg::XIP_FAST)
      rtOf = fogx_pkg::RT_FAST;
    else if (b == fogx_pkg::XIP_OCT_OUT)
      rtOf = fogx_pkg::RT_OCT_OUT;
    else if (b == fogx_pkg::XIP_OCT_IO)
      rtOf = fogx_pkg::RT_OCT_IO;
    else
      rtOf = fogx_pkg::RT_NONE;
  endfunction : rtOf

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fogx_pkg::fogx_state_t state_reg, state_next; // Operating state
  logic [SECT_W-1:0] susSect_reg, susSect_next; // Suspended sector
  logic [BANK_W-1:0] busyBank_reg, busyBank_next; // Bank in work
  logic              runErase_reg, runErase_next; // Sector erase run
  logic              accept_reg, accept_next;   // Accept pulse
  logic              reject_reg, reject_next;   // Reject pulse
  logic              unsure_reg, unsure_next;   // Unsure data pulse
  logic              start_reg, start_next;     // Engine start pulse
  logic              xip_reg, xip_next;         // XIP active
  logic [7:0]        cfg_reg, cfg_next;         // Volatile XIP byte
  fogx_pkg::fogx_rtype_t rt_reg, rt_next;       // Read selection
  logic              boot_reg, boot_next;       // Reload pending
  logic              rstPin_reg;                // Previous reset pin
  logic              ok;                        // Admission verdict
  logic              sectHit;                   // Suspended sector
  logic              rstPulse;                  // Reset pin rise

  // Pulse ends on the rising edge of the pin
  assign rstPulse = hwResetN && !rstPin_reg && extendedSpi;
  assign sectHit  = (cmdSector == susSect_reg);

  // ----------------------------------------------------------------
  // Admission table
  // ----------------------------------------------------------------
  // one state selects one column
  always_comb
  begin
    ok = 1'b0;
    case (state_reg)
      fogx_pkg::ST_STANDBY:
      begin
        // Everything except suspend and resume
        ok = (cmdOp != fogx_pkg::OP_SUSPEND) &&
             (cmdOp != fogx_pkg::OP_RESUME);
      end
      fogx_pkg::ST_PE,
      fogx_pkg::ST_NEST_PE:
      begin
        if (cmdOp == fogx_pkg::OP_REG_READ)
          ok = 1'b1;
        else if (cmdOp == fogx_pkg::OP_ARRAY_READ)
          ok = rwwOption && (cmdBank != busyBank_reg);
        else if (cmdOp == fogx_pkg::OP_SUSPEND)
          ok = (state_reg == fogx_pkg::ST_PE);
      end
      fogx_pkg::ST_PSUSP:
      begin
        ok = (cmdOp == fogx_pkg::OP_ARRAY_READ) ||
             (cmdOp == fogx_pkg::OP_REG_READ) ||
             (cmdOp == fogx_pkg::OP_LIGHT_WRITE) ||
             (cmdOp == fogx_pkg::OP_RESUME);
      end
      fogx_pkg::ST_ESUSP:
      begin
        if (cmdOp == fogx_pkg::OP_PROGRAM)
          ok = !sectHit;
        else
          ok = (cmdOp == fogx_pkg::OP_ARRAY_READ) ||
               (cmdOp == fogx_pkg::OP_REG_READ) ||
               (cmdOp == fogx_pkg::OP_LIGHT_WRITE) ||
               (cmdOp == fogx_pkg::OP_RESUME);
      end
      default:
        ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Operating state and answers
  // ----------------------------------------------------------------
  // recovery never touches this
  always_comb
  begin
    state_next    = state_reg;
    susSect_next  = susSect_reg;
    busyBank_next = busyBank_reg;
    runErase_next = runErase_reg;
    accept_next   = 1'b0;
    reject_next   = 1'b0;
    unsure_next   = 1'b0;
    start_next    = 1'b0;
    // Completion from the engine
    if (opDone)
    begin
      if (state_reg == fogx_pkg::ST_PE)
        state_next = fogx_pkg::ST_STANDBY;
      else if (state_reg == fogx_pkg::ST_NEST_PE)
        state_next = fogx_pkg::ST_ESUSP;
    end
    if (cmdValid && !ok)
      reject_next = 1'b1;
    else if (cmdValid)
    begin
      accept_next = 1'b1;
      case (cmdOp)
        fogx_pkg::OP_ERASE:
        begin
          state_next    = fogx_pkg::ST_PE;
          susSect_next  = cmdSector;
          busyBank_next = cmdBank;
          runErase_next = !cmdSubsector;
          start_next    = 1'b1;
        end
        fogx_pkg::OP_OTP_PROG,
        fogx_pkg::OP_CHIP_ERASE:
        begin
          state_next    = fogx_pkg::ST_PE;
          busyBank_next = cmdBank;
          runErase_next = 1'b0;
          start_next    = 1'b1;
        end
        // Program may nest in erase suspend
        fogx_pkg::OP_PROGRAM:
        begin
          start_next    = 1'b1;
          busyBank_next = cmdBank;
          if (state_reg == fogx_pkg::ST_ESUSP)
            state_next = fogx_pkg::ST_NEST_PE;
          else
          begin
            state_next    = fogx_pkg::ST_PE;
            runErase_next = 1'b0;
          end
        end
        // Subsector erase suspends like a program
        fogx_pkg::OP_SUSPEND:
          state_next = runErase_reg ? fogx_pkg::ST_ESUSP
                                    : fogx_pkg::ST_PSUSP;
        fogx_pkg::OP_RESUME:
          state_next = fogx_pkg::ST_PE;
        fogx_pkg::OP_ARRAY_READ:
          unsure_next = sectHit && runErase_reg == 1'b0 ?
                        (state_reg == fogx_pkg::ST_PSUSP &&
                         cmdSubsector) :
                        sectHit &&
                        (state_reg == fogx_pkg::ST_ESUSP);
        default:
          start_next = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // XIP control
  // ----------------------------------------------------------------
  // Reset pin and boot reload outrank every other source
  always_comb
  begin
    xip_next  = xip_reg;
    cfg_next  = cfg_reg;
    boot_next = 1'b0;
    // reset pin pulse reloads the boot setting, in extended SPI only
    if (boot_reg || rstPulse)
    begin
      cfg_next = nvXipByte;
      xip_next = xipValid(nvXipByte);
    end
    else if (lnk.exitPulse)
    begin
      xip_next = 1'b0;
      cfg_next = fogx_pkg::XIP_OFF;
    end
    // confirm bit on line zero only
    else if (dummyFirst && xipValid(cfg_reg))
    begin
      // confirm low enters or keeps XIP
      if (!dummyLines[fogx_pkg::CONF_LINE])
        xip_next = 1'b1;
      // confirm high leaves, byte to FFh
      else
      begin
        xip_next = 1'b0;
        cfg_next = fogx_pkg::XIP_OFF;
      end
    end
    // accepted volatile write of the XIP byte
    else if (cmdValid && ok && cmdXipByte &&
             cmdOp == fogx_pkg::OP_LIGHT_WRITE)
      cfg_next = cmdData;
    rt_next = rtOf(cfg_next);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg    <= fogx_pkg::ST_STANDBY;
      susSect_reg  <= '0;
      busyBank_reg <= '0;
      runErase_reg <= 1'b0;
      accept_reg   <= 1'b0;
      reject_reg   <= 1'b0;
      unsure_reg   <= 1'b0;
      start_reg    <= 1'b0;
      xip_reg      <= 1'b0;
      cfg_reg      <= fogx_pkg::XIP_OFF;
      rt_reg       <= fogx_pkg::RT_NONE;
      boot_reg     <= 1'b1;   // Reload setting after release
      rstPin_reg   <= 1'b1;
    end
    else
    begin
      state_reg    <= state_next;
      susSect_reg  <= susSect_next;
      busyBank_reg <= busyBank_next;
      runErase_reg <= runErase_next;
      accept_reg   <= accept_next;
      reject_reg   <= reject_next;
      unsure_reg   <= unsure_next;
      start_reg    <= start_next;
      xip_reg      <= xip_next;
      cfg_reg      <= cfg_next;
      rt_reg       <= rt_next;
      boot_reg     <= boot_next;
      rstPin_reg   <= hwResetN;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign cmdAccept  = accept_reg;
  assign cmdReject  = reject_reg;
  assign dataUnsure = unsure_reg;
  assign peStart    = start_reg;
  assign devState   = state_reg;
  assign xipActive  = xip_reg;
  // frames in XIP carry no command code
  assign addrOnly   = xip_reg;
  assign xipCfg     = cfg_reg;
  assign readType   = rt_reg;

endmodule : fogx_gate

`default_nettype wire

// >>> fogx_gate_properties.sv
/*
  Port-level timing checks for the operation gate.
  Assumes one clock domain with a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module fogx_gate_properties
(
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  rst_n,
  // Inputs watched
  input wire logic                  cmdValid,
  input wire fogx_pkg::fogx_op_t    cmdOp,
  input wire logic                  opDone,
  input wire logic                  dummyFirst,
  input wire logic [7:0]            dummyLines,
  // Outputs watched
  input wire logic                  cmdAccept,
  input wire logic                  cmdReject,
  input wire logic                  peStart,
  input wire fogx_pkg::fogx_state_t devState,
  input wire logic                  xipActive,
  input wire logic                  addrOnly,
  input wire logic [7:0]            xipCfg,
  input wire fogx_pkg::fogx_rtype_t readType
);
  // Confirm bit only counts while an XIP value is held
  logic xipArmed;
  assign xipArmed = xipCfg inside {8'hF8, 8'hFD, 8'hFE};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ------------------------------------------------------------
  // Admission
  // ------------------------------------------------------------
  answer_once_a: assert property (
    (cmdAccept | cmdReject) == $past(cmdValid) && !(cmdAccept && cmdReject))
    else $error("answer count wrong");
  reject_quiet_a: assert property (
    (cmdValid && !opDone) ##1 cmdReject |-> $stable(devState))
    else $error("refused moved state");
  suspend_gate_a: assert property (
    cmdValid && cmdOp == fogx_pkg::OP_SUSPEND
    |=> cmdAccept == ($past(devState) == fogx_pkg::ST_PE))
    else $error("suspend gating wrong");
  reg_read_a: assert property (
    cmdValid && cmdOp == fogx_pkg::OP_REG_READ |=> cmdAccept)
    else $error("register read refused");
  erase_gate_a: assert property (
    cmdValid && cmdOp == fogx_pkg::OP_ERASE |=> (cmdAccept && peStart)
    == ($past(devState) == fogx_pkg::ST_STANDBY))
    else $error("erase gating wrong");
  heavy_write_a: assert property (
    cmdValid && cmdOp inside {fogx_pkg::OP_STBY_WRITE,
    fogx_pkg::OP_OTP_PROG, fogx_pkg::OP_CHIP_ERASE}
    |=> cmdAccept == ($past(devState) == fogx_pkg::ST_STANDBY))
    else $error("heavy write gating wrong");
  light_write_a: assert property (
    cmdValid && cmdOp == fogx_pkg::OP_LIGHT_WRITE |=> cmdAccept !=
    ($past(devState) inside {fogx_pkg::ST_PE, fogx_pkg::ST_NEST_PE}))
    else $error("light write gating wrong");

  // ------------------------------------------------------------
  // XIP
  // ------------------------------------------------------------
  addr_only_a: assert property (addrOnly == xipActive)
    else $error("address-only differs");
  confirm_low_a: assert property (
    dummyFirst && xipArmed && !dummyLines[0] |=> xipActive)
    else $error("confirm low no entry");
  confirm_high_a: assert property (
    dummyFirst && xipArmed && dummyLines[0]
    |=> !xipActive && xipCfg == 8'hFF)
    else $error("confirm high no exit");
  read_type_a: assert property (
    readType == (xipCfg == 8'hF8 ? fogx_pkg::RT_FAST :
    xipCfg == 8'hFD ? fogx_pkg::RT_OCT_OUT :
    xipCfg == 8'hFE ? fogx_pkg::RT_OCT_IO : fogx_pkg::RT_NONE))
    else $error("read type wrong");

  // Main scenarios reached
  cover property (cmdValid && cmdOp == fogx_pkg::OP_SUSPEND ##1 cmdAccept);
  cover property (dummyFirst && xipArmed && !dummyLines[0]);
  cover property ($fell(xipActive) && !$past(dummyFirst));
endmodule : fogx_gate_properties

`default_nettype wire

// >>> fogx_gate_tb.sv
/*
  Self-checking bench for the operation gate.
  Assumes the host model drives the recovery pins.
*/
`timescale 1ns/1ps
`default_nettype none

module fogx_gate_tb;
  logic clk = 1'b0; // 40 MHz clock
  logic rst_n, cmdValid, cmdSubsector, cmdXipByte, opDone;
  logic rwwOption, extendedSpi, dummyFirst, hwResetN, go;
  logic sckPin, csN, dataLineZero;
  logic cmdAccept, cmdReject, dataUnsure, peStart, xipActive, addrOnly;
  logic [7:0] cmdSector, cmdData, nvXipByte, dummyLines, xipCfg;
  logic [1:0] cmdBank;
  fogx_pkg::fogx_op_t    cmdOp;
  fogx_pkg::fogx_state_t devState;
  fogx_pkg::fogx_rtype_t readType;
  int fails = 0;
  int n_tests = 0;
  localparam fogx_pkg::fogx_op_t SUS = fogx_pkg::OP_SUSPEND;
  localparam fogx_pkg::fogx_op_t RD = fogx_pkg::OP_ARRAY_READ;
  localparam fogx_pkg::fogx_op_t LW = fogx_pkg::OP_LIGHT_WRITE;

  always #12.5 clk = ~clk;

  fogx_gate dut_u (.clk(clk), .rst_n(rst_n), .cmdValid(cmdValid),
    .cmdOp(cmdOp), .cmdSector(cmdSector), .cmdBank(cmdBank),
    .cmdSubsector(cmdSubsector), .cmdXipByte(cmdXipByte),
    .cmdData(cmdData), .opDone(opDone), .rwwOption(rwwOption),
    .extendedSpi(extendedSpi), .nvXipByte(nvXipByte),
    .dummyFirst(dummyFirst), .dummyLines(dummyLines),
    .hwResetN(hwResetN), .sckPin(sckPin), .csN(csN),
    .dataLineZero(dataLineZero), .cmdAccept(cmdAccept),
    .cmdReject(cmdReject), .dataUnsure(dataUnsure), .peStart(peStart),
    .devState(devState), .xipActive(xipActive), .addrOnly(addrOnly),
    .xipCfg(xipCfg), .readType(readType));

  fogx_host_model host_u (.clk(clk), .go(go), .sckPin(sckPin),
    .csN(csN), .dataLineZero(dataLineZero));

  task close_out;
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  task chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask : chk

  // One command, answer judged in the cycle after it is taken
  task cmd(input fogx_pkg::fogx_op_t op, input logic acc,
           input logic [7:0] sec = 8'h05, input logic [1:0] bk = 2'h1,
           input logic sub = 1'b0);
    @(negedge clk);
    {cmdValid, cmdOp, cmdSector, cmdBank, cmdSubsector} =
      {1'b1, op, sec, bk, sub};
    @(negedge clk);
    cmdValid = 1'b0;
    chk(cmdAccept === acc && cmdReject === !acc, op.name());
  endtask : cmd

  task pulse_done;
    @(negedge clk);
    opDone = 1'b1;
    @(negedge clk);
    opDone = 1'b0;
  endtask : pulse_done

  task dum(input logic [7:0] l);
    @(negedge clk);
    {dummyFirst, dummyLines} = {1'b1, l};
    @(negedge clk);
    dummyFirst = 1'b0;
  endtask : dum

  task t_busy;
    cmd(SUS, 1'b0);
    cmd(fogx_pkg::OP_ERASE, 1'b1, 8'h05, 2'h1, 1'b1);
    chk(peStart === 1'b1 && devState === fogx_pkg::ST_PE, "pe");
    cmd(fogx_pkg::OP_REG_READ, 1'b1);
    cmd(fogx_pkg::OP_PROGRAM, 1'b0);
    cmd(fogx_pkg::OP_ERASE, 1'b0);
    cmd(fogx_pkg::OP_OTP_PROG, 1'b0);
    cmd(LW, 1'b0);
    cmd(RD, 1'b0, 8'h05, 2'h2);
    rwwOption = 1'b1;
    cmd(RD, 1'b1, 8'h05, 2'h2);
    cmd(RD, 1'b0, 8'h05, 2'h1);
    rwwOption = 1'b0;
    cmd(SUS, 1'b1);
    chk(devState === fogx_pkg::ST_PSUSP, "psusp");
    cmd(SUS, 1'b0);
    cmd(fogx_pkg::OP_PROGRAM, 1'b0, 8'h07);
    cmd(fogx_pkg::OP_CHIP_ERASE, 1'b0);
    cmd(LW, 1'b1);
    cmd(RD, 1'b1, 8'h05, 2'h1, 1'b1);
    chk(dataUnsure === 1'b1, "unsure psusp");
    cmd(fogx_pkg::OP_RESUME, 1'b1);
    pulse_done();
    chk(devState === fogx_pkg::ST_STANDBY, "idle");
  endtask : t_busy

  task t_esusp;
    cmd(fogx_pkg::OP_ERASE, 1'b1, 8'h09, 2'h0);
    cmd(SUS, 1'b1);
    chk(devState === fogx_pkg::ST_ESUSP, "esusp");
    cmd(fogx_pkg::OP_ERASE, 1'b0, 8'h03);
    cmd(fogx_pkg::OP_PROGRAM, 1'b0, 8'h09);
    cmd(fogx_pkg::OP_PROGRAM, 1'b1, 8'h08);
    cmd(SUS, 1'b0);
    pulse_done();
    cmd(RD, 1'b1, 8'h09, 2'h0);
    chk(dataUnsure === 1'b1, "unsure esusp");
    cmd(fogx_pkg::OP_RESUME, 1'b1);
    pulse_done();
  endtask : t_esusp

  task t_xip;
    logic [7:0] v [3] = '{8'hF8, 8'hFD, 8'hFE};
    fogx_pkg::fogx_rtype_t r [3] = '{fogx_pkg::RT_FAST,
      fogx_pkg::RT_OCT_OUT, fogx_pkg::RT_OCT_IO};
    cmdXipByte = 1'b1;
    foreach (v[i])
    begin
      cmdData = v[i];
      cmd(LW, 1'b1);
      chk(xipCfg === v[i] && readType === r[i], "rtype");
    end
    cmdXipByte = 1'b0;
    // Upper lines high must be ignored
    dum(8'hFE);
    chk(xipActive === 1'b1 && addrOnly === 1'b1, "enter");
    dum(8'h01);
    chk(xipActive === 1'b0 && xipCfg === 8'hFF, "exit");
  endtask : t_xip

  task t_recov;
    cmdXipByte = 1'b1;
    cmdData    = 8'hF8;
    cmd(LW, 1'b1);
    cmdXipByte = 1'b0;
    dum(8'h00);
    cmd(fogx_pkg::OP_ERASE, 1'b1);
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    for (int i = 0; i < 1000 && xipActive === 1'b1; i++) @(negedge clk);
    chk(xipActive === 1'b0 && xipCfg === 8'hFF, "recovery");
    chk(devState === fogx_pkg::ST_PE, "erase kept");
    pulse_done();
  endtask : t_recov

  task t_boot;
    nvXipByte = 8'hFE;
    rst_n     = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk(xipActive === 1'b1 && xipCfg === 8'hFE, "boot");
    dum(8'h01);
    hwResetN = 1'b0;
    repeat (2) @(negedge clk);
    hwResetN = 1'b1;
    repeat (4) @(negedge clk);
    chk(xipActive === 1'b1 && xipCfg === 8'hFE, "pin");
  endtask : t_boot

  // Main sequence
  initial
  begin
    {rst_n, cmdValid, cmdSubsector, cmdXipByte, opDone} = 5'h00;
    {rwwOption, dummyFirst, go, cmdSector, cmdData} = 19'h0;
    {cmdBank, dummyLines, cmdOp} = {2'h0, 8'h00, fogx_pkg::OP_REG_READ};
    {extendedSpi, hwResetN, nvXipByte} = {2'h3, 8'hFF};
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_busy();
    t_esusp();
    t_xip();
    t_recov();
    t_boot();
    close_out();
  end

  // Watchdog well past the expected run
  initial
  begin
    #(25 * 5000);
    fails++;
    close_out();
  end
endmodule : fogx_gate_tb

bind fogx_gate fogx_gate_properties chk_u (.clk(clk), .rst_n(rst_n),
  .cmdValid(cmdValid), .cmdOp(cmdOp), .opDone(opDone),
  .dummyFirst(dummyFirst), .dummyLines(dummyLines),
  .cmdAccept(cmdAccept), .cmdReject(cmdReject), .peStart(peStart),
  .devState(devState), .xipActive(xipActive), .addrOnly(addrOnly),
  .xipCfg(xipCfg), .readType(readType));

`default_nettype wire

// >>> fogx_host_model.sv
/*
  Host controller model: sends the XIP recovery burst pattern.
  Assumes go is raised for one clock by the bench.
*/
`timescale 1ns/1ps
`default_nettype none

module fogx_host_model
(
  // Clock and start
  input  wire logic clk,
  input  wire logic go,
  // Pins toward the device
  output var logic  sckPin,
  output var logic  csN,
  output var logic  dataLineZero
);
  int lens [5] = '{3, 4, 5, 25, 33};  // Burst clock counts

  // Each serial level lasts two clocks so every edge is seen
  initial
  begin
    sckPin       = 1'b0;
    csN          = 1'b1;
    dataLineZero = 1'b0;
    forever
    begin
      @(posedge clk iff go);
      foreach (lens[i])
      begin
        @(negedge clk);
        csN          = 1'b0;
        dataLineZero = 1'b1;
        repeat (2) @(negedge clk);
        repeat (lens[i])
        begin
          sckPin = 1'b1;
          repeat (2) @(negedge clk);
          sckPin = 1'b0;
          repeat (2) @(negedge clk);
        end
        // Released line shows the inverse
        csN          = 1'b1;
        dataLineZero = 1'b0;
        repeat (3) @(negedge clk);
      end
    end
  end
endmodule : fogx_host_model

`default_nettype wire

// >>> fogx_link_if.sv
/*
  Carrier between the gate and the XIP recovery detector.
  Assumes both ends sit in the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

interface fogx_link_if;
  logic sckPin;     // Sampled serial clock
  logic csN;        // Sampled chip select, active low
  logic dataZero;   // Sampled data_line_zero
  logic exitPulse;  // One-cycle XIP exit request

  // Detector end
  modport det
  (
    input  sckPin,
    input  csN,
    input  dataZero,
    output exitPulse
  );

  // Gate end
  modport gate
  (
    output sckPin,
    output csN,
    output dataZero,
    input  exitPulse
  );
endinterface : fogx_link_if

`default_nettype wire

// >>> fogx_pkg.sv
/*
  Constants and types for the operation gate and XIP control.
  Assumes opcodes already decoded into classes.
*/
`default_nettype none

package fogx_pkg;

  // ----------------------------------------------------------------
  // Device operating states
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    ST_STANDBY,     // Idle
    ST_PE,          // Program or erase running
    ST_PSUSP,       // Program or subsector erase suspended
    ST_ESUSP,       // Sector erase suspended
    ST_NEST_PE      // Program inside erase suspend
  } fogx_state_t;

  // ----------------------------------------------------------------
  // Operation classes from the command decoder
  // ----------------------------------------------------------------
  typedef enum logic [3:0]
  {
    OP_ARRAY_READ,  // Array read, fast reads included
    OP_REG_READ,    // Status and config reads
    OP_PROGRAM,     // Array program, one-time area excluded
    OP_ERASE,       // Sector or subsector erase
    OP_STBY_WRITE,  // Register writes allowed in standby only
    OP_OTP_PROG,    // One-time-programmable area program
    OP_CHIP_ERASE,  // Whole array erase
    OP_LIGHT_WRITE, // Volatile config, enables, flag clear
    OP_SUSPEND,     // Program or erase suspend
    OP_RESUME       // Program or erase resume
  } fogx_op_t;

  // ----------------------------------------------------------------
  // XIP read selection
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    RT_NONE,        // XIP not configured
    RT_FAST,        // Fast read
    RT_OCT_OUT,     // octal_output_fast_read
    RT_OCT_IO       // octal_io_fast_read
  } fogx_rtype_t;

  // ----------------------------------------------------------------
  // Configuration byte values
  // ----------------------------------------------------------------
  localparam logic [7:0] XIP_FAST      = 8'hF8; // Fast read XIP
  localparam logic [7:0] XIP_OCT_OUT   = 8'hFD; // Octal output XIP
  localparam logic [7:0] XIP_OCT_IO    = 8'hFE; // Octal in/out XIP
  localparam logic [7:0] XIP_OFF       = 8'hFF; // XIP disabled
  localparam int         CONF_LINE     = 0;     // Confirm bit line

  // ----------------------------------------------------------------
  // Recovery burst lengths, in serial clocks
  // ----------------------------------------------------------------
  localparam int         EXIT_STEPS = 5;
  localparam logic [5:0] BURST_0    = 6'h03;
  localparam logic [5:0] BURST_1    = 6'h04;
  localparam logic [5:0] BURST_2    = 6'h05;
  localparam logic [5:0] BURST_3    = 6'h19;
  localparam logic [5:0] BURST_4    = 6'h21;

endpackage : fogx_pkg

`default_nettype wire
